// ==== design/compare_capture_pwm_timer.sv ====
// 16-bit timer with four compare/capture registers and pwm
`timescale 1ns/1ns
`default_nettype none
module compare_capture_pwm_timer import timer_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // configuration
   input wire ctrl_t control_reg,
   input wire irq_en_t irq_enable_reg,
   // software writes
   input wire logic [3:0] gr_write,
   input wire logic [15:0] gr_wdata,
   input wire logic counter_write,
   input wire logic [15:0] counter_wdata,
   // status access
   input wire logic status_read,
   input wire logic status_write,
   input wire status_t status_wdata,
   // channel pins
   input wire logic ext_clk_in,
   input wire logic [3:0] channel_pin_in,
   output logic [3:0] channel_pin_out,
   output logic [3:0] channel_pin_oe_n,
   // state
   output logic [15:0] up_counter,
   output gr_array_t general_reg,
   output status_t status_reg,
   output logic timer_irq_request
);
   logic tick;
   logic any_pwm;
   logic clear_cnt;
   logic overflow;
   logic [15:0] up_counter_d;
   logic [3:0] is_pwm;
   logic [3:0] is_capture;
   logic [3:0] buffered;
   logic [3:0] eq;
   logic [3:0] match;
   logic [3:0] pin_edge;
   logic [3:0] capture;
   logic [3:0] cap_prev_q;
   logic [4:0] flag_set;
   logic [4:0] flag_clr;
   logic [4:0] armed_q;
   status_t status_d;

   count_tick_gen u_tick (
      .clk(clk),
      .reset_n(reset_n),
      .run(control_reg.count_start),
      .ext_sel(control_reg.ext_clock_sel),
      .prescale_sel(control_reg.prescale_sel),
      .ext_clk_in(ext_clk_in),
      .tick(tick)
   );

   assign any_pwm = |control_reg.pwm_enable;
   assign is_pwm = {control_reg.pwm_enable, 1'b0};

   // per-channel decode of use, match and capture
   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++) begin : g_dec
         // pwm forces every register into compare use
         assign is_capture[i] = (control_reg.func_select[i] == FUNC_CAPTURE) && !any_pwm;
         if (i < 2) begin : g_pri
            assign buffered[i] = 1'b0;
         end else begin : g_sec
            assign buffered[i] = control_reg.buffer_enable[i-2];
         end
         assign eq[i] = (up_counter == general_reg[i]);
         // match fires as the counter leaves the equal value
         assign match[i] = tick && eq[i] && !is_capture[i] && !buffered[i];
         always_comb begin
            if (control_reg.io_code[i][EDGE_BOTH_BIT]) begin
               pin_edge[i] = channel_pin_in[i] ^ cap_prev_q[i];
            end else if (control_reg.io_code[i] == EDGE_FALL) begin
               pin_edge[i] = !channel_pin_in[i] && cap_prev_q[i];
            end else begin
               pin_edge[i] = channel_pin_in[i] && !cap_prev_q[i];
            end
         end
         assign capture[i] = is_capture[i] && !buffered[i] && pin_edge[i];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cap_prev_q <= '0;
      end else begin
         cap_prev_q <= channel_pin_in;
      end
   end

   // counter: clear beats a software write, a write beats counting
   assign clear_cnt = match[CH_A] && control_reg.counter_clear_enable;
   assign overflow = tick && (up_counter == CNT_MAX) && !clear_cnt && !counter_write;

   always_comb begin
      if (clear_cnt) begin
         up_counter_d = CNT_RESET;
      end else if (counter_write) begin
         up_counter_d = counter_wdata;
      end else if (tick) begin
         up_counter_d = up_counter + 16'h0001;
      end else begin
         up_counter_d = up_counter;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         up_counter <= CNT_RESET;
      end else begin
         up_counter <= up_counter_d;
      end
   end

   // general registers with capture and buffer chaining
   generate
      for (i = 0; i < NUM_CH; i++) begin : g_gr
         logic hw_load;
         logic [15:0] hw_value;
         if (i < 2) begin : g_pri
            // primary: capture, or reload from its buffer at match
            always_comb begin
               if (capture[i]) begin
                  hw_load = 1'b1;
                  hw_value = up_counter;
               end else if (match[i] && control_reg.buffer_enable[i]) begin
                  hw_load = 1'b1;
                  hw_value = general_reg[i+2];
               end else begin
                  hw_load = 1'b0;
                  hw_value = general_reg[i];
               end
            end
         end else begin : g_sec
            // buffer: takes the old primary value at a primary capture
            always_comb begin
               if (buffered[i] && capture[i-2]) begin
                  hw_load = 1'b1;
                  hw_value = general_reg[i-2];
               end else if (capture[i]) begin
                  hw_load = 1'b1;
                  hw_value = up_counter;
               end else begin
                  hw_load = 1'b0;
                  hw_value = general_reg[i];
               end
            end
         end
         // hardware transfer wins over a software write in the same cycle
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               general_reg[i] <= GR_RESET;
            end else if (hw_load) begin
               general_reg[i] <= hw_value;
            end else if (gr_write[i]) begin
               general_reg[i] <= gr_wdata;
            end
         end
      end
   endgenerate

   // pin outputs
   generate
      for (i = 0; i < NUM_CH; i++) begin : g_pin
         logic same_as_period;
         assign same_as_period = (general_reg[i] == general_reg[CH_A]);
         // a stopped counter holds pins at their initial level
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               channel_pin_out[i] <= 1'b0;
            end else if (!control_reg.count_start) begin
               channel_pin_out[i] <= control_reg.initial_level[i];
            end else if (is_pwm[i]) begin
               if (same_as_period) begin
                  channel_pin_out[i] <= channel_pin_out[i];
               end else if (match[CH_A]) begin
                  channel_pin_out[i] <= control_reg.initial_level[i];
               end else if (match[i]) begin
                  channel_pin_out[i] <= !control_reg.initial_level[i];
               end
            end else if (match[i]) begin
               case (control_reg.io_code[i])
                  OUT_ZERO: begin
                     channel_pin_out[i] <= 1'b0;
                  end
                  OUT_ONE: begin
                     channel_pin_out[i] <= 1'b1;
                  end
                  OUT_TOGGLE: begin
                     channel_pin_out[i] <= !channel_pin_out[i];
                  end
                  default: begin
                     channel_pin_out[i] <= channel_pin_out[i];
                  end
               endcase
            end
         end
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               channel_pin_oe_n[i] <= 1'b1;
            end else begin
               channel_pin_oe_n[i] <= !(is_pwm[i] ||
                  (!is_capture[i] && !buffered[i] && control_reg.io_code[i] != OUT_NONE));
            end
         end
      end
   endgenerate

   // status flags: set wins over clear
   assign flag_set = {overflow, match | capture};
   assign flag_clr = {5{status_write}} & ~status_wdata & armed_q;
   assign status_d = (status_reg & ~flag_clr) | flag_set;

   // a flag arms only when read as one; any status write disarms
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         armed_q <= '0;
      end else if (status_write) begin
         armed_q <= '0;
      end else if (status_read) begin
         armed_q <= armed_q | status_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_d;
      end
   end

   // irq taken from next flags so it rises with the flag
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         timer_irq_request <= 1'b0;
      end else begin
         timer_irq_request <= |(status_d & irq_enable_reg);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_flag_a_armed;
      status_read && status_reg.match_flag[CH_A] && !status_write;
   endsequence

   sequence s_zero_write_a;
      status_write && !status_wdata.match_flag[CH_A] && !flag_set[CH_A];
   endsequence

   sequence s_pwm_b_period;
      control_reg.count_start && is_pwm[CH_B] && match[CH_A] &&
         general_reg[CH_B] != general_reg[CH_A];
   endsequence

   // a stop reaches the registered tick one clock late, so skip that clock
   chk_counter_hold: assert property (
      !control_reg.count_start ##1 !control_reg.count_start && !counter_write
         |=> $stable(up_counter))
      else $error("counter moved while stopped");

   chk_overflow_set: assert property (
      tick && up_counter == CNT_MAX && !counter_write && !clear_cnt
         |=> status_reg.overflow_flag && up_counter == CNT_RESET)
      else $error("wrap did not set overflow flag");

   chk_period_clear: assert property (
      match[CH_A] && control_reg.counter_clear_enable
         |=> up_counter == CNT_RESET && status_reg.match_flag[CH_A])
      else $error("match a did not clear counter");

   chk_pin_drive: assert property (
      control_reg.count_start && match[CH_B] && !is_pwm[CH_B] &&
         control_reg.io_code[CH_B] == OUT_ONE
         |=> channel_pin_out[CH_B])
      else $error("compare did not drive pin high");

   chk_capture_latch: assert property (
      capture[CH_B] |=> general_reg[CH_B] == $past(up_counter))
      else $error("capture value wrong");

   chk_buffer_shift: assert property (
      capture[CH_A] && control_reg.buffer_enable[0]
         |=> general_reg[2] == $past(general_reg[CH_A]) &&
            general_reg[CH_A] == $past(up_counter))
      else $error("capture buffer chain wrong");

   chk_pwm_start: assert property (
      s_pwm_b_period |=> channel_pin_out[CH_B] == $past(control_reg.initial_level[CH_B]))
      else $error("pwm pin not at start level");

   chk_match_flag: assert property (
      match[CH_B] && irq_enable_reg.match_irq_enable[CH_B]
         |=> status_reg.match_flag[CH_B] && timer_irq_request)
      else $error("match flag or irq late");

   chk_flag_clear: assert property (
      s_flag_a_armed ##1 s_zero_write_a |=> !status_reg.match_flag[CH_A])
      else $error("armed zero write did not clear");

   chk_flag_keep: assert property (
      (status_reg.match_flag[CH_A] && !armed_q[CH_A]) and s_zero_write_a
         |=> status_reg.match_flag[CH_A])
      else $error("unarmed zero write cleared flag");

   chk_irq_level: assert property (
      $stable(irq_enable_reg) |-> timer_irq_request == |(status_reg & irq_enable_reg))
      else $error("irq does not follow flags");

   chk_pwm_drive: assert property (
      is_pwm[CH_B] |=> !channel_pin_oe_n[CH_B])
      else $error("pwm pin not driven");

   chk_pwm_hold: assert property (
      control_reg.count_start && is_pwm[CH_B] && general_reg[CH_B] == general_reg[CH_A]
         |=> $stable(channel_pin_out[CH_B]))
      else $error("pwm pin moved with duty equal to period");

   chk_buffer_copy: assert property (
      match[CH_B] && control_reg.buffer_enable[1]
         |=> general_reg[CH_B] == $past(general_reg[3]))
      else $error("buffer d not copied into b");

   // without clearing, a match must still let the counter step on
   chk_match_advance: assert property (
      tick && eq[CH_A] && !is_capture[CH_A] && !control_reg.counter_clear_enable &&
         !counter_write
         |=> status_reg.match_flag[CH_A] && up_counter == $past(up_counter) + 16'h0001)
      else $error("match a out of step with counter");

   chk_capture_flag: assert property (
      capture[CH_A] |=> status_reg.match_flag[CH_A])
      else $error("capture did not set flag");

   chk_pin_toggle: assert property (
      control_reg.count_start && match[CH_A] && control_reg.io_code[CH_A] == OUT_TOGGLE
         |=> channel_pin_out[CH_A] != $past(channel_pin_out[CH_A]))
      else $error("compare did not toggle pin");

endmodule // compare_capture_pwm_timer
`default_nettype wire

// ==== design/count_tick_gen.sv ====
// count tick source: internal prescaler or external clock edge
`timescale 1ns/1ns
`default_nettype none
module count_tick_gen import timer_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // selection
   input wire logic run,
   input wire logic ext_sel,
   input wire logic [1:0] prescale_sel,
   // external count clock
   input wire logic ext_clk_in,
   // tick
   output logic tick
);
   logic [PRE_W-1:0] pre_q;
   logic ext_prev_q;
   logic int_tick;

   always_comb begin
      if (prescale_sel == PRE_DIV1) begin
         int_tick = 1'b1;
      end else if (prescale_sel == PRE_DIV2) begin
         int_tick = pre_q[0];
      end else if (prescale_sel == PRE_DIV4) begin
         int_tick = &pre_q[1:0];
      end else begin
         int_tick = &pre_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // pulses shorter than one clock may be lost here
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_clk_in;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tick <= 1'b0;
      end else begin
         tick <= run && (ext_sel ? (ext_clk_in && !ext_prev_q) : int_tick);
      end
   end
endmodule // count_tick_gen
`default_nettype wire

// ==== design/timer_pkg.sv ====
// constants, field layouts and carrier types for the compare/capture/pwm timer
// Notes on behaviour
// - counter resets free-running and counts only while count_start is one.
// - wrap from ffff to 0000 sets overflow_flag; irq when its enable is one.
// - compare A with counter_clear_enable clears counter, sets match_flag_a.
// - periodic mode with register A holding N counts 0..N, period N+1.
// - compare match drives pin 0, 1 or toggles; same level stays unchanged.
// - capture latches counter on selected rising, falling or both pin edges.
// - with C buffering capturing A, old A moves to C, counter into A.
// - pwm uses A as period and B, C, D as duty on pins B, C, D.
// - pwm forces compare use and ignores per-pin compare output codes.
// - pwm pin goes initial level at match A, inverse at duty match.
// - duty equal to period leaves that pwm pin unchanged at match.
// - D buffering B in pwm: match B changes pin unless B equals A, copies D to B.
// - pwm with clear by A resets counter at match A, pins to start level.
// - match fires as counter leaves the equal value on the next count tick.
// - compare match sets its flag and raises the irq in the same cycle.
// - capture sets that register's flag when the capture occurs.
// - flag clears only by read-as-one then write zero; lone zero write ignored.
// - function bit 0 is compare, 1 capture; output code 00 means no change.
// - compare output code 01 drives 0, 10 drives 1, 11 toggles.
// - capture edge code 00 rising, 01 falling, 1x both edges.
// - reset sets general registers to ffff and counter to 0000.
package timer_pkg;

   localparam int NUM_CH = 4;
   localparam int CH_A = 0;
   localparam int CH_B = 1;
   localparam int PRE_W = 3;

   localparam logic [15:0] GR_RESET = 16'hffff;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;

   localparam logic FUNC_COMPARE = 1'b0;
   localparam logic FUNC_CAPTURE = 1'b1;

   localparam logic [1:0] OUT_NONE = 2'h0;
   localparam logic [1:0] OUT_ZERO = 2'h1;
   localparam logic [1:0] OUT_ONE = 2'h2;
   localparam logic [1:0] OUT_TOGGLE = 2'h3;

   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam int EDGE_BOTH_BIT = 1;

   localparam logic [1:0] PRE_DIV1 = 2'h0;
   localparam logic [1:0] PRE_DIV2 = 2'h1;
   localparam logic [1:0] PRE_DIV4 = 2'h2;

   typedef logic [3:0][15:0] gr_array_t;

   typedef struct packed {
      logic count_start;
      logic counter_clear_enable;
      logic ext_clock_sel;
      logic [1:0] prescale_sel;
      logic [1:0] buffer_enable;
      logic [2:0] pwm_enable;
      logic [3:0] initial_level;
      logic [3:0] func_select;
      logic [3:0][1:0] io_code;
   } ctrl_t;

   typedef struct packed {
      logic overflow_irq_enable;
      logic [3:0] match_irq_enable;
   } irq_en_t;

   typedef struct packed {
      logic overflow_flag;
      logic [3:0] match_flag;
   } status_t;

endpackage

// ==== tb/pin_partner.sv ====
// capture-pin driver and wire resolver for the timer channels
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
   // clock
   input wire logic clk,
   // pin side of the timer
   input wire logic [3:0] pin_out,
   input wire logic [3:0] oe_n,
   output logic [3:0] pin_in
);
   logic [3:0] drv_q = 4'h0;

   // a pin the timer drives reads back its own level
   assign pin_in = (oe_n & drv_q) | (~oe_n & pin_out);

   // hold each level four clocks so no edge is too short to see
   task automatic set_level(input int ch, input logic v);
      @(negedge clk);
      drv_q[ch] = v;
      repeat (4) @(negedge clk);
   endtask
endmodule // pin_partner
`default_nettype wire

// ==== tb/test_compare_capture_pwm_timer.sv ====
// self-checking bench for the compare/capture/pwm timer
`timescale 1ns/1ns
`default_nettype none
module test_compare_capture_pwm_timer import timer_pkg::*; ;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   ctrl_t ctrl;
   irq_en_t ien;
   logic [3:0] gr_write;
   logic [15:0] gr_wdata;
   logic counter_write;
   logic [15:0] counter_wdata;
   logic status_read;
   logic status_write;
   status_t status_wdata;
   wire logic [3:0] pin_in;
   logic [3:0] pin_out;
   logic [3:0] oe_n;
   logic [15:0] up_counter;
   gr_array_t gr;
   status_t st;
   logic irq;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   logic ext_clk = 1'b0;

   compare_capture_pwm_timer dut_u (.clk(clk), .reset_n(reset_n), .control_reg(ctrl),
      .irq_enable_reg(ien), .gr_write(gr_write), .gr_wdata(gr_wdata),
      .counter_write(counter_write), .counter_wdata(counter_wdata),
      .status_read(status_read), .status_write(status_write), .status_wdata(status_wdata),
      .ext_clk_in(ext_clk), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
      .channel_pin_oe_n(oe_n), .up_counter(up_counter), .general_reg(gr),
      .status_reg(st), .timer_irq_request(irq));

   pin_partner pins_u (.clk(clk), .pin_out(pin_out), .oe_n(oe_n), .pin_in(pin_in));

   always #2 clk = ~clk;

   // tests need a few hundred cycles; a hang stops well past that
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wr_gr(input int i, input logic [15:0] v);
      @(negedge clk);
      gr_write = 4'(4'h1 << i);
      gr_wdata = v;
      @(negedge clk);
      gr_write = 4'h0;
   endtask

   task automatic wr_cnt(input logic [15:0] v);
      @(negedge clk);
      counter_write = 1'b1;
      counter_wdata = v;
      @(negedge clk);
      counter_write = 1'b0;
   endtask

   task automatic wait_cnt(input logic [15:0] v);
      int n;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (up_counter !== v && n < 40);
      chk("counter_reach", v, up_counter);
   endtask

   // read every flag as set, then write zeros to clear them all
   task automatic clr_flags();
      @(negedge clk);
      status_read = 1'b1;
      @(negedge clk);
      status_read = 1'b0;
      status_write = 1'b1;
      status_wdata = '0;
      @(negedge clk);
      status_write = 1'b0;
   endtask

   task automatic t_reset();
      chk("counter", CNT_RESET, up_counter);
      for (int i = 0; i < 4; i++) chk("general_reg", GR_RESET, gr[i]);
      tick(10);
      chk("stopped_counter", CNT_RESET, up_counter);
      $display("test reset done");
   endtask

   task automatic t_overflow();
      int n;
      ien.overflow_irq_enable = 1'b1;
      wr_cnt(16'hfff0);
      ctrl.count_start = 1'b1;
      n = 0;
      while (st.overflow_flag !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk("overflow_flag", 16'h1, 16'(st.overflow_flag));
      chk("wrap_value", CNT_RESET, up_counter);
      chk("irq_overflow", 16'h1, 16'(irq));
      ctrl.count_start = 1'b0;
      ien.overflow_irq_enable = 1'b0;
      tick(3);
      chk("irq_masked", 16'h0, 16'(irq));
      $display("test overflow done");
   endtask

   task automatic t_flag_clear();
      @(negedge clk);
      status_write = 1'b1;
      status_wdata = '0;
      @(negedge clk);
      status_write = 1'b0;
      tick(1);
      chk("unread_clear", 16'h1, 16'(st.overflow_flag));
      status_read = 1'b1;
      @(negedge clk);
      status_read = 1'b0;
      status_write = 1'b1;
      @(negedge clk);
      status_write = 1'b0;
      tick(1);
      chk("read_clear", 16'h0, 16'(st));
      $display("test flag_clear done");
   endtask

   task automatic t_periodic();
      int last;
      int period;
      int flips;
      int odd;
      int top;
      logic p;
      wr_cnt(16'h0000);
      wr_gr(CH_A, 16'h0005);
      ctrl.counter_clear_enable = 1'b1;
      ctrl.io_code[CH_A] = OUT_TOGGLE;
      ien.match_irq_enable = 4'h1;
      ctrl.count_start = 1'b1;
      last = -1;
      period = 0;
      flips = 0;
      odd = 0;
      top = 0;
      p = pin_out[0];
      for (int c = 0; c < 40; c++) begin
         tick(1);
         if (int'(up_counter) > top) top = int'(up_counter);
         if (pin_out[0] !== p) begin
            flips++;
            if (up_counter !== 16'h0000) odd++;
         end
         p = pin_out[0];
         if (up_counter === 16'h0000) begin
            if (last >= 0) period = c - last;
            last = c;
         end
      end
      chk("period", 16'd6, 16'(period));
      chk("top_count", 16'd5, 16'(top));
      chk("toggle_seen", 16'h1, 16'(flips >= 5));
      chk("toggle_off_match", 16'h0, 16'(odd));
      chk("match_flag_a", 16'h1, 16'(st.match_flag[0]));
      chk("irq_match", 16'h1, 16'(irq));
      chk("oe_n_a", 16'h0, 16'(oe_n[0]));
      $display("test periodic done");
   endtask

   task automatic t_codes();
      for (int k = 0; k < 3; k++) begin
         ctrl.count_start = 1'b0;
         ctrl.io_code[CH_B] = 2'(k);
         ctrl.initial_level[CH_B] = (k == 1);
         wr_gr(CH_B, 16'h0002);
         ctrl.count_start = 1'b1;
         // twenty cycles span at least three matches, so a repeated level must hold
         tick(20);
         if (k == 0) chk("oe_n_b", 16'h1, 16'(oe_n[1]));
         else chk("pin_b", 16'(k == 2), 16'(pin_out[1]));
      end
      ctrl.count_start = 1'b0;
      $display("test codes done");
   endtask

   task automatic t_capture();
      ctrl.counter_clear_enable = 1'b0;
      ctrl.io_code = '0;
      ctrl.func_select[CH_A] = FUNC_CAPTURE;
      for (int k = 0; k < 3; k++) begin
         ctrl.io_code[CH_A] = 2'(k);
         ctrl.buffer_enable[0] = (k == 2);
         clr_flags();
         chk("capture_flag_clear", 16'h0, 16'(st.match_flag[0]));
         wr_cnt(16'(16'h0100 + k));
         pins_u.set_level(0, 1'b1);
         wr_cnt(16'(16'h0200 + k));
         pins_u.set_level(0, 1'b0);
         chk("capture_a", 16'((k == 0) ? 16'h0100 + k : 16'h0200 + k), gr[0]);
         chk("capture_flag", 16'h1, 16'(st.match_flag[0]));
         if (k == 2) chk("buffer_c", 16'h0102, gr[2]);
      end
      $display("test capture done");
   endtask

   task automatic t_pwm();
      ctrl.func_select = '0;
      ctrl.buffer_enable = 2'b10;
      ctrl.io_code = '0;
      // function and output code on b must be overridden by pwm
      ctrl.func_select[CH_B] = FUNC_CAPTURE;
      ctrl.io_code[CH_B] = OUT_ZERO;
      ctrl.pwm_enable = 3'b001;
      ctrl.initial_level[CH_B] = 1'b1;
      ctrl.counter_clear_enable = 1'b1;
      wr_cnt(16'h0000);
      wr_gr(CH_A, 16'h0009);
      wr_gr(CH_B, 16'h0003);
      wr_gr(3, 16'h0006);
      ctrl.count_start = 1'b1;
      wait_cnt(16'h0005);
      chk("pwm_duty", 16'h0, 16'(pin_out[1]));
      chk("pwm_oe_n", 16'h0, 16'(oe_n[1]));
      chk("buffer_b", 16'h0006, gr[1]);
      wait_cnt(16'h0009);
      wait_cnt(16'h0001);
      chk("pwm_period", 16'h1, 16'(pin_out[1]));
      wait_cnt(16'h0005);
      chk("pwm_held", 16'h1, 16'(pin_out[1]));
      wait_cnt(16'h0008);
      chk("pwm_new_duty", 16'h0, 16'(pin_out[1]));
      // duty equal to period: a changed start level must not show up
      ctrl.buffer_enable = 2'b00;
      wr_gr(CH_B, 16'h0009);
      ctrl.initial_level[CH_B] = 1'b0;
      wait_cnt(16'h0009);
      wait_cnt(16'h0001);
      chk("pwm_equal_hold", 16'h1, 16'(pin_out[1]));
      $display("test pwm done");
   endtask

   task automatic t_clock_src();
      ctrl = '0;
      wr_cnt(16'h0000);
      ctrl.ext_clock_sel = 1'b1;
      ctrl.count_start = 1'b1;
      for (int k = 0; k < 3; k++) begin
         ext_clk = 1'b1;
         tick(2);
         ext_clk = 1'b0;
         tick(2);
      end
      ctrl.count_start = 1'b0;
      tick(2);
      chk("ext_count", 16'h0003, up_counter);
      ctrl.ext_clock_sel = 1'b0;
      ctrl.prescale_sel = PRE_DIV4;
      wr_cnt(16'h0000);
      ctrl.count_start = 1'b1;
      // forty enabled clocks hold exactly ten divide-by-four ticks
      tick(40);
      ctrl.count_start = 1'b0;
      tick(2);
      chk("div4_count", 16'h000a, up_counter);
      $display("test clock_src done");
   endtask

   initial begin
      ctrl = '0;
      ien = '0;
      gr_write = 4'h0;
      gr_wdata = 16'h0000;
      counter_write = 1'b0;
      counter_wdata = 16'h0000;
      status_read = 1'b0;
      status_write = 1'b0;
      status_wdata = '0;
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      t_reset();
      t_overflow();
      t_flag_clear();
      t_periodic();
      t_codes();
      t_capture();
      t_pwm();
      t_clock_src();
      end_sim();
   end
endmodule // test_compare_capture_pwm_timer
`default_nettype wire
